// ===== core/rct_core.sv
// run control, boot sequencing, system tick and expansion bus clock
//
// Register access over Avalon-MM and the address map were left to the implementer.
`include "rct_params.svh"
// Function
// RULE1: switch in stop always holds application stopped
// RULE2: switch run runs only if host last run
// RULE3: stop halts, back to run resumes per host
// RULE4: switch reset halts at once, nothing kept
// RULE5: leaving reset repeats the power-up sequence
// RULE6: host reset command also resets the device
// RULE7: only flash contents survive power loss
// RULE8: every start copies boot image into ram
// RULE9: host must reload ram-only programs after reset
// RULE10: load image, restore retained, then maybe start
// RULE11: last host run always starts stored image
// RULE12: host link accepted only after boot finishes
// RULE13: one tick paces tasks and hardware access
// RULE14: tick period in microseconds, 100 to 3000
// RULE15: tick period resets to 1000
// RULE16: task cycles are whole multiples of tick
// RULE17: expansion bus 10 MHz, 5 MHz with slow module
// RULE18: sensor read must fit in one tick
// RULE19: leave sensor recovery gap before next tick
// RULE20: task compute stays under seventy percent
// RULE21: microsecond counter emits one-cycle tick at period
// RULE22: out-of-range tick writes rejected, old value kept
module rct_core
    import rct_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  sw_pos,
    input  wire logic        slow_module,
    input  wire logic        image_present,
    input  wire logic        retained_used,
    input  wire logic        load_done,
    input  wire logic        restore_done,
    input  wire logic [11:0] ssi_us,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             app_run,
    output logic             cpu_halt,
    output logic             load_start,
    output logic             restore_start,
    output logic             host_ready,
    output logic             tick,
    output logic             ebus_clk
);
    // switch codes: 0 stop, 1 run, 2 reset
    logic [1:0]  sw_s1;                 // first sync stage
    logic [1:0]  sw_s2;                 // second sync stage
    logic [1:0]  aux_s1;                // sync stage for level inputs
    logic [1:0]  aux_s2;                // synced slow_module, image_present
    // host side state
    logic        host_run;              // last host commanded run state
    logic        host_rst;              // one-cycle host reset pulse
    // time base counters
    logic [11:0] tick_period;           // accepted period in us
    logic [11:0] us_cnt;                // microseconds since last tick
    logic [7:0]  cyc_cnt;               // clocks within a microsecond
    logic [7:0]  eb_cnt;                // half period of bus clock
    // fault flags and bus answer
    logic        ssi_fault;             // sensor read as long as the tick or longer
    logic        range_fault;           // last tick write rejected
    logic        ack;                   // bus answer cycle
    // boot sequencer
    rct_boot_t   state;                 // boot sequencer state
    rct_boot_t   next_state;

    // switch position decode; code 3 matches none of stop, run or reset, so it cannot run
    wire sw_stop   = (sw_s2 == 2'd0);
    wire sw_run    = (sw_s2 == 2'd1);
    wire sw_reset  = (sw_s2 == 2'd2);
    wire any_rst   = sw_reset | host_rst;           // RULE6
    // bus decode; control and period writes are dropped until the host link opens
    wire req       = avs_read | avs_write;
    wire take      = req & ack;
    wire wr_ctrl   = take & avs_write & (avs_address == `RCT_CTRL_OFS) & host_ready; // RULE12
    wire wr_tick   = take & avs_write & (avs_address == `RCT_TICK_OFS) & host_ready;
    wire [11:0] wr_val = avs_writedata[11:0];
    wire tick_ok   = (avs_writedata[31:12] == 20'h0) &
                     (wr_val >= `RCT_TICK_MIN) & (wr_val <= `RCT_TICK_MAX);  // RULE14
    // microsecond and tick strobes, bus clock divisor
    wire us_pulse  = (cyc_cnt == `RCT_US_CYCLES - 8'd1);
    wire tick_hit  = us_pulse & (us_cnt == tick_period - 12'd1);            // RULE21
    wire [7:0] eb_div = aux_s2[0] ? `RCT_EBUS_SLOW_DIV : `RCT_EBUS_FAST_DIV; // RULE17
    // status word: run, ready, booted, image present
    wire rct_status_t stat = '{run: app_run, ready: host_ready,
                               booted: (state == RCT_READY), image_ok: aux_s2[1]};

    // sw_pos, image_present and slow_module pass two flip-flops before use
    always_ff @(posedge clk) begin
        sw_s1  <= sw_pos;
        sw_s2  <= sw_s1;
        aux_s1 <= {image_present, slow_module};
        aux_s2 <= aux_s1;
    end

    // boot sequencer next state
    always_comb begin
        next_state = state;
        unique case (state)
            RCT_HALT:    if (!sw_reset) next_state = RCT_LOAD;               // RULE5
            RCT_LOAD:    if (!aux_s2[1] || load_done) next_state = RCT_RESTORE; // RULE8 RULE10
            RCT_RESTORE: if (!retained_used || restore_done) next_state = RCT_DECIDE; // RULE10
            RCT_DECIDE:  next_state = RCT_READY;
            RCT_READY:   next_state = RCT_READY;
        endcase
        // any reset source overrides the step above
        if (any_rst) begin
            next_state = RCT_HALT;                                           // RULE4
        end
    end

    // sequencer register; reset drops everything volatile
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= RCT_HALT;
        end else begin
            state <= next_state;
        end
    end

    // start pulses for flash copy and retained restore
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            load_start    <= 1'b0;
            restore_start <= 1'b0;
        end else begin
            load_start    <= (state == RCT_HALT) & (next_state == RCT_LOAD) & aux_s2[1]; // RULE8
            restore_start <= (state == RCT_LOAD) & (next_state == RCT_RESTORE) & retained_used;
        end
    end

    // run decision: host run state is kept as flash state, so it survives switch and host resets
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            app_run <= 1'b0;
        end else if (any_rst || state != RCT_READY) begin
            app_run <= 1'b0;                                                 // RULE4
        end else begin
            app_run <= sw_run & host_run & aux_s2[1];                        // RULE1 RULE2 RULE3 RULE11
        end
    end

    // halt line and host readiness
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpu_halt   <= 1'b1;
            host_ready <= 1'b0;
        end else begin
            cpu_halt   <= (next_state == RCT_HALT);                          // RULE4
            host_ready <= (next_state == RCT_READY);                         // RULE12
        end
    end

    // host run flag and reset command; run flag is non-volatile, rst_n clears it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            host_run <= 1'b0;                                                // RULE7
            host_rst <= 1'b0;
        end else begin
            host_rst <= wr_ctrl & avs_writedata[`RCT_CTRL_RST_BIT];          // RULE6
            if (wr_ctrl) begin
                host_run <= avs_writedata[`RCT_CTRL_RUN_BIT];
            end
        end
    end

    // tick period register with range check
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tick_period <= `RCT_TICK_RESET;                                  // RULE15
            range_fault <= 1'b0;
        end else if (wr_tick) begin
            range_fault <= !tick_ok;
            if (tick_ok) begin
                tick_period <= wr_val;                                       // RULE22
            end
        end
    end

    // sensor read length must fit inside one tick; recovery gap is left to software
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ssi_fault <= 1'b0;
        end else begin
            ssi_fault <= (ssi_us >= tick_period);                            // RULE18
        end
    end

    // microsecond prescaler and tick counter
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cyc_cnt <= 8'h00;
            us_cnt  <= 12'h000;
            tick    <= 1'b0;
        end else begin
            cyc_cnt <= us_pulse ? 8'h00 : cyc_cnt + 8'h01;
            tick    <= tick_hit;                                             // RULE13 RULE21
            if (tick_hit || (us_pulse && us_cnt >= tick_period - 12'd1)) begin
                us_cnt <= 12'h000;
            end else if (us_pulse) begin
                us_cnt <= us_cnt + 12'h001;
            end
        end
    end

    // expansion bus clock divider
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            eb_cnt   <= 8'h00;
            ebus_clk <= 1'b0;
        end else if (eb_cnt >= eb_div - 8'd1) begin
            eb_cnt   <= 8'h00;
            ebus_clk <= ~ebus_clk;                                           // RULE17
        end else begin
            eb_cnt <= eb_cnt + 8'h01;
        end
    end

    // bus slave: one wait cycle, then answer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0;
        end else begin
            ack <= req & !ack;
            if (req & !ack & avs_read) begin
                unique case (avs_address)
                    `RCT_CTRL_OFS: avs_readdata <= {31'h0, host_run};
                    `RCT_TICK_OFS: avs_readdata <= {20'h0, tick_period};
                    `RCT_STAT_OFS: avs_readdata <= {26'h0, ssi_fault, range_fault, stat};
                    default:       avs_readdata <= 32'h0;
                endcase
            end
        end
    end
    // one wait state on every request; the answer comes in the next cycle
    assign avs_waitrequest = req & !ack;

    // assertions on run gating, boot order, bus gate and tick
    // stop position never lets the application run
    stop_holds_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
        sw_stop |=> !app_run) else $error("app ran in stop");
    // running needs the host run state one cycle before
    run_needs_host_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        app_run |-> $past(host_run)) else $error("run without host run");
    // switch reset halts the processor and the application
    reset_halts_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        sw_reset |=> cpu_halt && !app_run) else $error("reset did not halt");
    // host link opens only as the sequence steps from decide into ready
    ready_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
        $rose(host_ready) |-> state == RCT_READY && $past(state) == RCT_DECIDE)
        else $error("ready early");
    // period register starts at its default after reset
    tick_default_a: assert property (@(posedge clk) // RULE15
        !rst_n |=> tick_period == 12'd1000) else $error("bad default");
    // accepted period never leaves the legal span
    tick_range_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE14 RULE22
        tick_period >= 12'd100 && tick_period <= 12'd3000) else $error("period out of range");
    // tick is a single-cycle pulse
    tick_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
        tick |=> !tick) else $error("tick wider than one");
    // host reset command sends the sequencer back to halt
    host_rst_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        host_rst |=> state == RCT_HALT) else $error("host reset ignored");

    // image copy starts only on leaving halt
    load_order_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE8 RULE5
        load_start |-> state == RCT_LOAD && $past(state) == RCT_HALT) else $error("copy out of order");
    // restore follows the image copy, never the other way
    restore_order_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
        restore_start |-> state == RCT_RESTORE && $past(state) == RCT_LOAD)
        else $error("restore out of order");
    // control writes before the host link opens are dropped
    host_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
        !host_ready && avs_write && !avs_waitrequest && avs_address == `RCT_CTRL_OFS
        |=> $stable(host_run)) else $error("control write taken before ready");
    // rejected period writes keep the old value and flag it
    reject_keeps_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE22
        wr_tick && !tick_ok |=> $stable(tick_period) && range_fault) else $error("bad period kept");
    // each tick lines up with the microsecond count restarting
    tick_align_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
        tick |-> us_cnt == 12'h000) else $error("tick off its count");
    // ready state with every run condition starts the image
    auto_start_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
        state == RCT_READY && sw_run && host_run && aux_s2[1] && !host_rst |=> app_run)
        else $error("stored image not started");
    // halted processor neither runs nor talks to the host
    halt_excl_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        cpu_halt |-> !app_run && !host_ready) else $error("halt not exclusive");
    // bus clock only toggles at the end of a divider count
    ebus_step_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
        $changed(ebus_clk) |-> eb_cnt == 8'h00) else $error("bus clock edge off count");
    // sensor read as long as the tick or longer raises the fault
    ssi_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
        ssi_us >= tick_period |=> ssi_fault) else $error("sensor overrun missed");

    // main scenarios to be reached
    cov_run_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(app_run));
    cov_tick_c: cover property (@(posedge clk) disable iff (!rst_n) tick);
    cov_rej_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(range_fault));
    cov_boot_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(host_ready));
    cov_hrst_c: cover property (@(posedge clk) disable iff (!rst_n) host_rst);
endmodule : rct_core

// ===== core/rct_params.svh
// constants for the run control and system tick block
`ifndef RCT_PARAMS_SVH
`define RCT_PARAMS_SVH
`define RCT_CTRL_OFS        4'h0
`define RCT_TICK_OFS        4'h1
`define RCT_STAT_OFS        4'h2
`define RCT_CTRL_RUN_BIT    0
`define RCT_CTRL_RST_BIT    1
`define RCT_TICK_MIN        12'd100
`define RCT_TICK_MAX        12'd3000
`define RCT_TICK_RESET      12'd1000
`define RCT_CLK_MHZ         200
`define RCT_US_CYCLES       8'((`RCT_CLK_MHZ * 1000) / 1000)
`define RCT_EBUS_FAST_DIV   8'd10
`define RCT_EBUS_SLOW_DIV   8'd20
`define RCT_EBUS_FAST_US    12'd42
`define RCT_EBUS_SLOW_US    12'd84
`define RCT_SSI_WORST_US    12'd410
`define RCT_FAULT_RANGE_BIT 0
`define RCT_FAULT_SSI_BIT   1
`endif

// ===== core/rct_pkg.sv
// types for the run control and system tick block
package rct_pkg;
    typedef enum logic [2:0] {
        RCT_HALT,
        RCT_LOAD,
        RCT_RESTORE,
        RCT_DECIDE,
        RCT_READY
    } rct_boot_t;
    typedef struct packed {
        logic        run;
        logic        ready;
        logic        booted;
        logic        image_ok;
    } rct_status_t;
endpackage : rct_pkg

// ===== verif/rct_host_model.sv
// boot loader and flash responder that answers the block's start pulses
module rct_host_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic load_start,
    input  wire logic restore_start,
    output logic      load_done,
    output logic      restore_done,
    output int        load_cnt,
    output int        restore_cnt,
    output logic      order_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    int   ld_wait;  // cycles until the image copy ends
    int   rs_wait;  // cycles until retained values are back
    logic loaded;   // image copied since the last start
    // answer each start after a random short or long delay
    always @(posedge clk) begin
        load_done    <= 1'b0;
        restore_done <= 1'b0;
        if (!rst_n) begin
            {ld_wait, rs_wait, load_cnt, restore_cnt} <= '0;
            loaded    <= 1'b0;
            order_bad <= 1'b0;
        end else begin
            if (ld_wait > 0) ld_wait <= ld_wait - 1;
            if (rs_wait > 0) rs_wait <= rs_wait - 1;
            if (ld_wait == 1) load_done <= 1'b1;
            if (ld_wait == 1) loaded <= 1'b1;
            if (rs_wait == 1) restore_done <= 1'b1;
            // image copy into ram
            if (load_start) begin
                ld_wait  <= 1 + $urandom % 20;
                load_cnt <= load_cnt + 1;
                loaded   <= 1'b0;
            end
            // restore must follow a finished copy
            if (restore_start) begin
                if (!loaded) order_bad <= 1'b1;
                rs_wait     <= 1 + $urandom % 20;
                restore_cnt <= restore_cnt + 1;
            end
        end
    end
endmodule : rct_host_model

// ===== verif/testbench.sv
// self-checking bench for run control, boot order and tick
`include "rct_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, slow_module, image_present, retained_used;
    logic [1:0]  sw_pos;
    logic [11:0] ssi_us;
    logic [3:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, e, m, seed, r;
    logic        app_run, cpu_halt, load_start, restore_start, load_done, restore_done;
    logic        host_ready, tick, ebus_clk, order_bad;
    int          load_cnt, restore_cnt, bad_count, samples_checked;
    logic [31:0] exp_q[$], msk_q[$];  // expected read data and care mask
    rct_core dut (.clk(clk), .rst_n(rst_n), .sw_pos(sw_pos), .slow_module(slow_module),
        .image_present(image_present), .retained_used(retained_used), .load_done(load_done),
        .restore_done(restore_done), .ssi_us(ssi_us), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .app_run(app_run),
        .cpu_halt(cpu_halt), .load_start(load_start), .restore_start(restore_start),
        .host_ready(host_ready), .tick(tick), .ebus_clk(ebus_clk));
    rct_host_model host (.clk(clk), .rst_n(rst_n), .load_start(load_start),
        .restore_start(restore_start), .load_done(load_done), .restore_done(restore_done),
        .load_cnt(load_cnt), .restore_cnt(restore_cnt), .order_bad(order_bad));
    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // count and report one comparison
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : check
    // one avalon cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [31:0] ex, input logic [31:0] mk);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        if (!wr) begin
            exp_q.push_back(ex);
            msk_q.push_back(mk);
        end
        // wait for the slave's answer; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    // wait for boot to finish, bounded
    task automatic wait_ready();
        int n;
        n = 0;
        while (host_ready !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        check(host_ready === 1'b1, "boot did not finish");
    endtask : wait_ready
    // time between two rising edges of a periodic output, in cycles
    task automatic period(input logic is_tick, input int want);
        realtime t0;
        if (is_tick) @(posedge tick); else @(posedge ebus_clk);
        t0 = $realtime;
        if (is_tick) @(posedge tick); else @(posedge ebus_clk);
        check(($realtime - t0) == want * 5.0, "wrong period");
    endtask : period
    // take the oldest note whenever read data is returned
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            check((avs_readdata & m) === (e & m), "read data mismatch");
        end
    end
    // verdict and end of run
    task summarize();
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // cut a hang short
    initial begin
        #400us;
        bad_count++;
        summarize();
    end
    // main sequence
    initial begin
        {rst_n, slow_module, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {image_present, retained_used, sw_pos, ssi_us} = {2'b11, 2'd1, 12'd50};
        {bad_count, samples_checked} = '0;
        seed = $urandom(32'hc94f7e62);
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wait_ready();
        check(load_cnt == 1 && restore_cnt == 1 && !order_bad, "boot order");
        check(app_run === 1'b0, "ran without host run");
        bus(0, `RCT_TICK_OFS, 0, 32'd1000, 32'hfff);
        bus(0, 4'h5, 0, 32'h0, 32'hffffffff);
        bus(1, `RCT_CTRL_OFS, 32'h1, 0, 0);
        repeat (6) @(posedge clk);
        check(app_run === 1'b1, "host run ignored");
        sw_pos <= 2'd0;
        repeat (6) @(posedge clk);
        check(app_run === 1'b0, "stop ignored");
        sw_pos <= 2'd3;
        repeat (6) @(posedge clk);
        check(app_run === 1'b0, "code 3 ran");
        sw_pos <= 2'd1;
        repeat (6) @(posedge clk);
        check(app_run === 1'b1, "no resume");
        r = 32'd100 + $urandom % 2901;
        bus(1, `RCT_TICK_OFS, r, 0, 0);
        bus(0, `RCT_TICK_OFS, 0, r, 32'hfff);
        bus(1, `RCT_TICK_OFS, 32'd99, 0, 0);
        bus(1, `RCT_TICK_OFS, 32'd3001, 0, 0);
        bus(0, `RCT_TICK_OFS, 0, r, 32'hfff);
        bus(0, `RCT_STAT_OFS, 0, 32'h10, 32'h10);
        bus(1, `RCT_TICK_OFS, 32'd100, 0, 0);
        ssi_us <= 12'd100;
        repeat (3) @(posedge clk);
        bus(0, `RCT_STAT_OFS, 0, 32'h20, 32'h20);
        period(1, 100 * `RCT_CLK_MHZ);
        period(0, `RCT_CLK_MHZ / 10);
        slow_module <= 1'b1;
        repeat (6) @(posedge clk);
        period(0, `RCT_CLK_MHZ / 5);
        sw_pos <= 2'd2;
        repeat (6) @(posedge clk);
        check(cpu_halt === 1'b1 && app_run === 1'b0, "reset did not halt");
        bus(1, `RCT_CTRL_OFS, 32'h0, 0, 0);
        sw_pos <= 2'd1;
        wait_ready();
        check(load_cnt == 2 && restore_cnt == 2 && !order_bad, "restart order");
        repeat (6) @(posedge clk);
        check(app_run === 1'b1, "image not restarted");
        retained_used <= 1'b0;
        bus(1, `RCT_CTRL_OFS, 32'h3, 0, 0);
        repeat (2) @(posedge clk);
        wait_ready();
        check(load_cnt == 3 && restore_cnt == 2, "host reset boot");
        summarize();
    end
endmodule : testbench
